/* File: twc_regs.svh */
// Register offsets, field positions and reset values of the two-wire controller
`ifndef TWC_REGS_SVH
`define TWC_REGS_SVH
`define TWC_ADDR_W 6
`define TWC_OFF_RAW 6'h00
`define TWC_OFF_MASK 6'h04
`define TWC_OFF_CLEAR 6'h08
`define TWC_OFF_CFG_A 6'h0c
`define TWC_OFF_CFG_B 6'h10
`define TWC_OFF_CFG_C 6'h14
`define TWC_OFF_SLAVE_ID 6'h18
`define TWC_OFF_TDATA 6'h1c
`define TWC_OFF_TTARGET 6'h20
`define TWC_OFF_CMD 6'h24
`define TWC_EVT_W 4
`define TWC_BIT_ARB 3
`define TWC_BIT_NOACK 2
`define TWC_BIT_STOP 1
`define TWC_BIT_ACK 0
`define TWC_ARB_ENA_BIT 28
`define TWC_MASK_RST 4'hf
`define TWC_RAW_RST 4'h0
`define TWC_WORD_RST 32'h0000_0000
`endif

/* File: twc_pkg.sv */
// Types shared by the two-wire controller register block
package twc_pkg;
   typedef logic [3:0] twc_evt_type;
   typedef logic [31:0] twc_word_type;
   typedef enum logic [1:0] {TWC_IDLE, TWC_ANSWER} twc_bus_state_type;
endpackage

/* File: twc_evt_if.sv */
// Event flag carrier between the register decoder and the flag bank
`timescale 1ns/1ps
interface twc_evt_if;
   logic [3:0] set_req;
   logic [3:0] clr_req;
   logic [3:0] flags;
   modport bank (input set_req, input clr_req, output flags);
   modport ctrl (output set_req, output clr_req, input flags);
endinterface

/* File: twc_flag_bit.sv */
// One sticky event flag, set wins over clear
`timescale 1ns/1ps
`include "twc_regs.svh"
module twc_flag_bit (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic set_req,
   input wire logic clr_req,
   output logic flag
);
   logic flag_nxt;

   // Event in the clear cycle survives
   assign flag_nxt = set_req | (flag & ~clr_req);

   // Flag storage
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         flag <= 1'b0;
      else
         flag <= flag_nxt;
   end
endmodule

/* File: twc_irq_regs.sv */
// Register decode, event flags and interrupt of the two-wire controller
// Function
// - Read-only raw status holds flags 3..0.
// - Arbitration lost sets bit 3.
// - Missing acknowledge sets bit 2.
// - Stop finished sets bit 1.
// - Peripheral acknowledge sets bit 0.
// - Mask register, one masks, resets 0xf.
// - Interrupt when unmasked flag set.
// - Clear register writes one to clear.
// - Ten word registers decoded 0x00 to 0x24.
// - Arbitration loss reported only when enabled.
`timescale 1ns/1ps
`include "twc_regs.svh"
module twc_irq_regs (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic EVT_ARB_LOST,
   input wire logic EVT_NO_ACK,
   input wire logic EVT_STOP_DONE,
   input wire logic EVT_ACK_DONE,
   output logic IRQ,
   output logic [31:0] CFG_A,
   output logic [31:0] CFG_B,
   output logic [31:0] CFG_C,
   output logic [31:0] OWN_SLAVE_ID,
   output logic [31:0] TRANSFER_DATA,
   output logic [31:0] TRANSFER_TARGET,
   output logic [31:0] COMMAND_WORD,
   output logic COMMAND_STROBE
);
   twc_evt_if evt ();

   twc_pkg::twc_bus_state_type state_r;
   twc_pkg::twc_bus_state_type state_nxt;
   twc_pkg::twc_evt_type mask_r;
   twc_pkg::twc_evt_type mask_nxt;
   twc_pkg::twc_evt_type evt_in;
   logic [3:0] evt_s1_r;
   logic [3:0] evt_s2_r;
   logic [3:0] evt_prev_r;
   logic [31:0] be_mask;
   logic [31:0] rdata_nxt;
   logic req;
   logic wr_hit;
   logic sel_raw;
   logic sel_mask;
   logic sel_clear;
   logic sel_cfg_a;
   logic sel_cfg_b;
   logic sel_cfg_c;
   logic sel_slave;
   logic sel_tdata;
   logic sel_ttarget;
   logic sel_cmd;
   logic irq_nxt;
   logic arb_ena;
   logic [3:0] evt_rise;
   logic [3:0] evt_gate;
   logic [31:0] cfg_a_nxt;
   logic [31:0] cfg_b_nxt;
   logic [31:0] cfg_c_nxt;
   logic [31:0] own_slave_id_nxt;
   logic [31:0] transfer_data_nxt;
   logic [31:0] transfer_target_nxt;
   logic [31:0] command_word_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Event inputs come from the serial engine pins, so synchronise them

   assign evt_in = {EVT_ARB_LOST, EVT_NO_ACK, EVT_STOP_DONE, EVT_ACK_DONE};

   // Two-stage synchroniser
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         evt_s1_r <= `TWC_RAW_RST;
         evt_s2_r <= `TWC_RAW_RST;
      end
      else
      begin
         evt_s1_r <= evt_in;
         evt_s2_r <= evt_s1_r;
      end
   end

   // Edge memory, reads only the second stage
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         evt_prev_r <= `TWC_RAW_RST;
      else
         evt_prev_r <= evt_s2_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave decode

   // Fixed one-cycle wait, answer on the cycle after the request
   // A request still held in its answer cycle is not taken twice
   assign req = (AVS_READ | AVS_WRITE) & (state_r == twc_pkg::TWC_IDLE);
   assign state_nxt = req ? twc_pkg::TWC_ANSWER : twc_pkg::TWC_IDLE;
   assign wr_hit = AVS_WRITE & (state_r == twc_pkg::TWC_IDLE);
   assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                     {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   assign sel_raw = (AVS_ADDRESS == `TWC_OFF_RAW);
   assign sel_mask = (AVS_ADDRESS == `TWC_OFF_MASK);
   assign sel_clear = (AVS_ADDRESS == `TWC_OFF_CLEAR);
   assign sel_cfg_a = (AVS_ADDRESS == `TWC_OFF_CFG_A);
   assign sel_cfg_b = (AVS_ADDRESS == `TWC_OFF_CFG_B);
   assign sel_cfg_c = (AVS_ADDRESS == `TWC_OFF_CFG_C);
   assign sel_slave = (AVS_ADDRESS == `TWC_OFF_SLAVE_ID);
   assign sel_tdata = (AVS_ADDRESS == `TWC_OFF_TDATA);
   assign sel_ttarget = (AVS_ADDRESS == `TWC_OFF_TTARGET);
   assign sel_cmd = (AVS_ADDRESS == `TWC_OFF_CMD);

   // Bus handshake state
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         state_r <= twc_pkg::TWC_IDLE;
      else
         state_r <= state_nxt;
   end

   // Waitrequest high until the answer cycle
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         AVS_WAITREQUEST <= 1'b1;
      else
         AVS_WAITREQUEST <= ~req;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flags

   assign arb_ena = CFG_A[`TWC_ARB_ENA_BIT];

   // Rising edges of the synchronised pins, a held level sets once
   assign evt_rise = evt_s2_r & ~evt_prev_r;

   // only with multi-master enabled, arbitration is the top bit
   assign evt_gate = {arb_ena, {(`TWC_EVT_W - 1){1'b1}}};
   assign evt.set_req = evt_rise & evt_gate;

   // write one to clear, zeros ignored
   assign evt.clr_req = (wr_hit & sel_clear & AVS_BYTEENABLE[0])
                        ? AVS_WRITEDATA[3:0] : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < `TWC_EVT_W; gi = gi + 1)
      begin : g_flag
         twc_flag_bit u_flag (
            .clk(CLK_SYS),
            .rst_b(RST_B),
            .set_req(evt.set_req[gi]),
            .clr_req(evt.clr_req[gi]),
            .flag(evt.flags[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Mask and interrupt

   assign mask_nxt = (wr_hit & sel_mask & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[3:0] : mask_r;

   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         mask_r <= `TWC_MASK_RST;
      else
         mask_r <= mask_nxt;
   end

   assign irq_nxt = |(evt.flags & ~mask_r);

   // Registered output, one cycle behind the flags
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         IRQ <= 1'b0;
      else
         IRQ <= irq_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and transfer registers, byte-lane writes

   // Byte-lane merge of each word, kept out of the flops
   assign cfg_a_nxt = (wr_hit & sel_cfg_a)
      ? ((CFG_A & ~be_mask) | (AVS_WRITEDATA & be_mask)) : CFG_A;
   assign cfg_b_nxt = (wr_hit & sel_cfg_b)
      ? ((CFG_B & ~be_mask) | (AVS_WRITEDATA & be_mask)) : CFG_B;
   assign cfg_c_nxt = (wr_hit & sel_cfg_c)
      ? ((CFG_C & ~be_mask) | (AVS_WRITEDATA & be_mask)) : CFG_C;
   assign own_slave_id_nxt = (wr_hit & sel_slave)
      ? ((OWN_SLAVE_ID & ~be_mask) | (AVS_WRITEDATA & be_mask)) : OWN_SLAVE_ID;
   assign transfer_data_nxt = (wr_hit & sel_tdata)
      ? ((TRANSFER_DATA & ~be_mask) | (AVS_WRITEDATA & be_mask)) : TRANSFER_DATA;
   assign transfer_target_nxt = (wr_hit & sel_ttarget)
      ? ((TRANSFER_TARGET & ~be_mask) | (AVS_WRITEDATA & be_mask)) : TRANSFER_TARGET;
   assign command_word_nxt = (wr_hit & sel_cmd)
      ? ((COMMAND_WORD & ~be_mask) | (AVS_WRITEDATA & be_mask)) : COMMAND_WORD;

   // Read-write words
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CFG_A <= `TWC_WORD_RST;
         CFG_B <= `TWC_WORD_RST;
         CFG_C <= `TWC_WORD_RST;
         OWN_SLAVE_ID <= `TWC_WORD_RST;
         TRANSFER_DATA <= `TWC_WORD_RST;
         TRANSFER_TARGET <= `TWC_WORD_RST;
      end
      else
      begin
         CFG_A <= cfg_a_nxt;
         CFG_B <= cfg_b_nxt;
         CFG_C <= cfg_c_nxt;
         OWN_SLAVE_ID <= own_slave_id_nxt;
         TRANSFER_DATA <= transfer_data_nxt;
         TRANSFER_TARGET <= transfer_target_nxt;
      end
   end

   // Command word and its one-cycle launch pulse for the serial engine
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
      begin
         COMMAND_WORD <= `TWC_WORD_RST;
         COMMAND_STROBE <= 1'b0;
      end
      else
      begin
         COMMAND_STROBE <= wr_hit & sel_cmd;
         COMMAND_WORD <= command_word_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   // clear, command, reserved and unmapped read zero
   always_comb
   begin
      rdata_nxt = `TWC_WORD_RST;
      if (sel_raw)
         rdata_nxt = {28'h0000000, evt.flags};
      else if (sel_mask)
         rdata_nxt = {28'h0000000, mask_r};
      else if (sel_cfg_a)
         rdata_nxt = CFG_A;
      else if (sel_cfg_b)
         rdata_nxt = CFG_B;
      else if (sel_cfg_c)
         rdata_nxt = CFG_C;
      else if (sel_slave)
         rdata_nxt = OWN_SLAVE_ID;
      else if (sel_tdata)
         rdata_nxt = TRANSFER_DATA;
      else if (sel_ttarget)
         rdata_nxt = TRANSFER_TARGET;
   end

   // Read data captured with a read request, held until the next read request
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         AVS_READDATA <= `TWC_WORD_RST;
      else if (req & AVS_READ)
         AVS_READDATA <= rdata_nxt;
   end
endmodule

/* File: twc_irq_regs_sva.sv */
// Bus timing and interrupt checks of the two-wire controller registers
`timescale 1ns/1ps
module twc_irq_regs_sva (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic IRQ,
   input wire logic [31:0] CFG_A,
   input wire logic COMMAND_STROBE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   logic wr_seen_r;
   wire rd_take = AVS_READ && AVS_WAITREQUEST;
   wire wr_take = AVS_WRITE && AVS_WAITREQUEST;
   ////////////////////////////////////////
   // Mask resets to all ones, so no interrupt before a first write
   always_ff @(posedge CLK_SYS or negedge RST_B)
      if (!RST_B)
         wr_seen_r <= 1'b0;
      else if (wr_take)
         wr_seen_r <= 1'b1;
   a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST) else $error("request not answered after one wait");
   a_answer_one_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait release longer than one cycle");
   a_reserved_bits_zero: assert property (rd_take && AVS_ADDRESS <= 6'h08
      |=> AVS_READDATA[31:4] == 28'h0) else $error("reserved bits not zero");
   a_wo_reads_zero: assert property (rd_take && AVS_ADDRESS inside {6'h08, 6'h24}
      |=> AVS_READDATA == 32'h0) else $error("write-only register read nonzero");
   a_cfg_a_write: assert property (wr_take && AVS_ADDRESS == 6'h0c && &AVS_BYTEENABLE
      |=> CFG_A == $past(AVS_WRITEDATA)) else $error("config word not stored");
   a_cmd_strobe: assert property (wr_take && AVS_ADDRESS == 6'h24
      |=> ##[0:1] COMMAND_STROBE) else $error("command strobe missing");
   a_strobe_single: assert property (COMMAND_STROBE |=> !COMMAND_STROBE)
      else $error("command strobe too long");
   a_irq_masked_reset: assert property (!wr_seen_r |-> !IRQ)
      else $error("interrupt while mask at reset value");
   a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(AVS_WRITE)
      || $past(AVS_WRITE, 2)) else $error("interrupt dropped without a write");
endmodule
bind twc_irq_regs twc_irq_regs_sva u_twc_irq_regs_sva (
   .CLK_SYS(CLK_SYS),
   .RST_B(RST_B),
   .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .IRQ(IRQ),
   .CFG_A(CFG_A),
   .COMMAND_STROBE(COMMAND_STROBE)
);

/* File: twc_evt_src.sv */
// Event source standing for the serial engine and its bus peers
`timescale 1ns/1ps
module twc_evt_src #(
   parameter int HOLD = 3
) (
   input wire logic clk,
   input wire logic [3:0] fire,
   output logic [3:0] evt
);
   int cnt [4] = '{default: 0};
   initial evt = 4'h0;
   ////////////////////////////////////////
   // stop reported once finished
   // Pins stay high a few cycles, like a slow peer holding a level
   always @(posedge clk)
      for (int i = 0; i < 4; i++)
      begin
         cnt[i] <= fire[i] ? HOLD : (cnt[i] > 0 ? cnt[i] - 1 : 0);
         evt[i] <= fire[i] || cnt[i] > 1;
      end
endmodule

/* File: twc_irq_regs_tb.sv */
// Self-checking bench of the two-wire controller register block
`timescale 1ns/1ps
module twc_irq_regs_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] seen;
   logic [3:0] fire = 4'h0;
   logic [3:0] evt;
   logic wait_req;
   logic irq;
   logic [31:0] cfg_out [6];
   logic [31:0] cmd_word;
   int errors = 0;
   int tests_run = 0;
   // Design, event source and clock
   twc_irq_regs u_twc_irq_regs (.CLK_SYS(clk), .RST_B(rst_b), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .EVT_ARB_LOST(evt[3]),
      .EVT_NO_ACK(evt[2]), .EVT_STOP_DONE(evt[1]), .EVT_ACK_DONE(evt[0]), .IRQ(irq),
      .CFG_A(cfg_out[0]), .CFG_B(cfg_out[1]), .CFG_C(cfg_out[2]),
      .OWN_SLAVE_ID(cfg_out[3]), .TRANSFER_DATA(cfg_out[4]), .TRANSFER_TARGET(cfg_out[5]),
      .COMMAND_WORD(cmd_word), .COMMAND_STROBE());
   twc_evt_src u_twc_evt_src (.clk(clk), .fire(fire), .evt(evt));
   initial
   begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // Avalon master: hold until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wait_req !== 1'b0 && n < 20);
      seen = rdata;
      if (n >= 20)
         errors++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(seen, exp);
   endtask
   // Interrupt is registered, so look at it half a cycle later
   task automatic irqchk(input logic exp);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      fire <= m;
      @(posedge clk);
      fire <= 4'h0;
      repeat (6) @(posedge clk);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #800000;
      errors++;
      test_done;
   end
   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(6'h00, 32'h0);
      rdchk(6'h04, 32'hf);
      for (int i = 2; i < 11; i++)
      begin
         bus(1'b1, 6'(i * 4), 32'ha5c3_0000 + i);
         if (i >= 3 && i <= 8)
            chk(cfg_out[i - 3], 32'ha5c3_0000 + i);
         if (i == 9)
            chk(cmd_word, 32'ha5c3_0009);
         rdchk(6'(i * 4), i inside {2, 9, 10} ? 32'h0 : 32'ha5c3_0000 + i);
      end
      bus(1'b1, 6'h00, 32'hf);
      rdchk(6'h00, 32'h0);
      bus(1'b1, 6'h04, 32'h0);
      pulse(4'h8);
      rdchk(6'h00, 32'h0);
      irqchk(1'b0);
      bus(1'b1, 6'h04, 32'hf);
      bus(1'b1, 6'h0c, 32'h1000_0000);
      for (int b = 0; b < 4; b++)
      begin
         pulse(4'(1 << b));
         rdchk(6'h00, 32'(1 << b));
         irqchk(1'b0);
         bus(1'b1, 6'h04, 32'hf ^ 32'(1 << b));
         irqchk(1'b1);
         bus(1'b1, 6'h08, 32'h0);
         rdchk(6'h00, 32'(1 << b));
         bus(1'b1, 6'h08, 32'(1 << b));
         rdchk(6'h00, 32'h0);
         irqchk(1'b0);
         bus(1'b1, 6'h04, 32'hf);
         // Pin edge lands in the very cycle of a clear write: the event survives
         fork
            pulse(4'(1 << b));
            begin
               repeat (3) @(posedge clk);
               bus(1'b1, 6'h08, 32'(1 << b));
            end
         join
         rdchk(6'h00, 32'(1 << b));
         bus(1'b1, 6'h08, 32'(1 << b));
      end
      test_done;
   end
endmodule
